// file: common/cwg_evt_if.sv
// Purpose: Carries one event selector's sources, masks and result.
// Assumes: Sources already synchronised to clock.
// Notes: One instance per edge direction.
`timescale 1ns/1ps
interface cwg_evt_if;
  logic [cwg_pkg::SRC_N-1:0] src;
  logic [cwg_pkg::SRC_N-1:0] enable;
  logic [cwg_pkg::SRC_N-1:0] level_mode;
  logic hit;
  modport sel (input src, input enable, input level_mode, output hit);
  modport user (output src, output enable, output level_mode, input hit);
endinterface

// file: common/cwg_pkg.sv
// Purpose: Constants, register map and types of the complementary
//   waveform generator.
// Assumes: Classic Wishbone slave, 8-bit registers on 32-bit words.
// Notes: Summary below names each behaviour kept by the design.
// Summary of operation
// RQ1: Outputs and fault input routable to alternate pins
// RQ2: Generator keeps running while sleep is asserted
// RQ3: Fast oscillator held on in sleep when enabled and selected
// RQ4: Software clears analog select on used pins
// RQ5: Software leaves output pins as inputs first
// RQ6: Software clears enable before writing configuration
// RQ7: Software writes counts while generator is disabled
// RQ8: Software picks shutdown sources before enabling
// RQ9: Software sets both override levels before start
// RQ10: Software sets shutdown active, clears auto-restart
// RQ11: Software selects event sources and modes first
// RQ12: Software selects clock and dead-band sources first
// RQ13: Software sets polarities and output enables first
// RQ14: Software turns used pins to outputs after enable
// RQ15: Setting auto-restart clears shutdown active automatically
// RQ16: Clearing shutdown active starts on rising event
// RQ17: Each set source bit enables one rising source
// RQ18: Bit 1 selects second comparator as source
// RQ19: Cleared fault bit keeps fault from rising event
// RQ20: Disabled generator loads count buffers on write
package cwg_pkg;
  // ----------------------------------------------------------
  // Widths
  // ----------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int SRC_N = 7;
  localparam int CNT_N = 6;

  // ----------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------
  localparam logic [7:0] ADR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADR_RISE_SRC = 8'h08;
  localparam logic [7:0] ADR_FALL_SRC = 8'h0c;
  localparam logic [7:0] ADR_RISE_MODE = 8'h10;
  localparam logic [7:0] ADR_FALL_MODE = 8'h14;
  localparam logic [7:0] ADR_SD_CTRL = 8'h18;
  localparam logic [7:0] ADR_SD_SRC = 8'h1c;
  localparam logic [7:0] ADR_ALT_PIN = 8'h20;
  localparam logic [5:0] CNT_BASE_WORD = 6'h09;
  localparam logic [7:0] ADR_STATUS = 8'h3c;

  // ----------------------------------------------------------
  // Count register indices, from 0x24 upward
  // ----------------------------------------------------------
  localparam int CI_DBR = 0;
  localparam int CI_DBF = 1;
  localparam int CI_BKR = 2;
  localparam int CI_BKF = 3;
  localparam int CI_PHR = 4;
  localparam int CI_PHF = 5;

  // ----------------------------------------------------------
  // Fields
  // ----------------------------------------------------------
  localparam int CO_EN = 0;
  localparam int CO_POL_P = 1;
  localparam int CO_POL_C = 2;
  localparam int CO_OE_P = 3;
  localparam int CO_OE_C = 4;
  localparam int CO_LOAD = 5;
  localparam int CT_CLK_LSB = 0;
  localparam logic [1:0] CLK_SRC_SYS = 2'h0;
  localparam logic [1:0] CLK_SRC_FAST = 2'h1;
  localparam logic [1:0] CLK_SRC_DIV = 2'h2;
  localparam int SD_ACTIVE = 0;
  localparam int SD_RESTART = 1;
  localparam int SD_OVR_P = 2;
  localparam int SD_OVR_C = 3;
  localparam int SS_FAULT = 0;
  localparam int SS_CMP_A = 1;
  localparam int SS_CMP_B = 2;
  localparam int RS_CMP_A = 0;
  localparam int RS_CMP_B = 1;
  localparam int RS_CCP = 2;
  localparam int RS_FAULT = 3;
  localparam int RS_TMR = 4;
  localparam int RS_HLT_A = 5;
  localparam int RS_HLT_B = 6;
  localparam int AP_PRIM = 0;
  localparam int AP_COMPL = 1;
  localparam int AP_FAULT = 2;

  // ----------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 100;
  localparam int GEN_DIV_NS = 400;
  localparam int GEN_DIV_CYCLES = GEN_DIV_NS / CLK_PERIOD_NS;
  localparam logic [3:0] DIV_LAST = 4'(GEN_DIV_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_SHUT = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } cwg_state_t;
endpackage

// file: design/cwg_event_sel.sv
// Purpose: Combines enabled event sources into one event.
// Assumes: Mode bit high means level, low means rising edge.
// Notes: Result is combinational from the synced sources.
`timescale 1ns/1ps
module cwg_event_sel (
  input wire logic clock,
  input wire logic reset,
  cwg_evt_if.sel port
);
  logic [cwg_pkg::SRC_N-1:0] prev_q;
  wire logic [cwg_pkg::SRC_N-1:0] rise_w;
  wire logic [cwg_pkg::SRC_N-1:0] act_w;

  assign rise_w = port.src & ~prev_q;
  assign act_w = (port.level_mode & port.src) | (~port.level_mode & rise_w);
  // Cleared enable bits drop their source entirely
  assign port.hit = |(port.enable & act_w); // RQ17 RQ18 RQ19

  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= port.src;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_none_enabled_quiet: assert property (@(posedge clock) disable iff (reset) // RQ17
    (port.enable == '0) |-> !port.hit)
    else $error("event raised with every source disabled");
  chk_cmp_b_level: assert property (@(posedge clock) disable iff (reset) // RQ18
    (port.enable[cwg_pkg::RS_CMP_B] && port.src[cwg_pkg::RS_CMP_B]
     && (port.level_mode[cwg_pkg::RS_CMP_B] || !prev_q[cwg_pkg::RS_CMP_B])) |-> port.hit)
    else $error("second comparator level not taken as event");
  chk_fault_ignored: assert property (@(posedge clock) disable iff (reset) // RQ19
    (!port.enable[cwg_pkg::RS_FAULT] && port.src[cwg_pkg::RS_FAULT]
     && ((port.enable & port.src) == '0)) |-> !port.hit)
    else $error("fault pin raised event while deselected");
endmodule

// file: design/cwg_top.sv
// Purpose: Complementary waveform generator with Wishbone registers.
// Assumes: External event sources and fault pins are asynchronous.
// Notes: Ack comes one cycle after request; unmapped reads give zero.
`timescale 1ns/1ps
module cwg_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic src_comparator_a,
  input wire logic src_comparator_b,
  input wire logic src_capture_compare,
  input wire logic src_timer_period_match,
  input wire logic src_halfbridge_a,
  input wire logic src_halfbridge_b,
  input wire logic [1:0] fault_input_pin,
  input wire logic sleep_active,
  output logic [1:0] primary_output,
  output logic [1:0] primary_drive,
  output logic [1:0] complementary_output,
  output logic [1:0] complementary_drive,
  output logic fast_osc_keep_on
);
  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] ctl1_q, ctl2_q, ris_q, fis_q, rsim_q, fsim_q, sdc_q, sds_q, alt_q;
  logic [7:0] sdc_d, ctl1_d;
  logic [cwg_pkg::CNT_W-1:0] cnt_reg_q [cwg_pkg::CNT_N];
  logic [cwg_pkg::CNT_W-1:0] cnt_buf_q [cwg_pkg::CNT_N];
  logic [7:0] sync1_q, sync2_q;
  logic [3:0] div_q;
  cwg_pkg::cwg_state_t state_q, state_d;
  logic wave_q, rise_pend_q, fall_pend_q;
  logic [cwg_pkg::CNT_W-1:0] rise_wait_q, fall_wait_q, rise_blank_q, fall_blank_q, db_q;
  logic [1:0] prim_q, prim_drv_q, compl_q, compl_drv_q;
  logic osc_q;

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic [7:0] adr = {wb_adr_i[7:2], 2'b00};
  wire logic [5:0] cnt_off = wb_adr_i[7:2] - cwg_pkg::CNT_BASE_WORD;
  wire logic cnt_hit = (wb_adr_i[7:2] >= cwg_pkg::CNT_BASE_WORD) && (cnt_off < 6'(cwg_pkg::CNT_N));
  wire logic [7:0] wdat = wb_dat_i[7:0];
  wire logic [cwg_pkg::CNT_W-1:0] wdat_cnt = wb_dat_i[cwg_pkg::CNT_W-1:0];
  // Writes land on the edge where the master sees ack
  wire logic wr_fire = req & wb_we_i & ack_q & wb_sel_i[0];
  wire logic wr_ctl1 = wr_fire && adr == cwg_pkg::ADR_CTRL_ONE;
  wire logic wr_ctl2 = wr_fire && adr == cwg_pkg::ADR_CTRL_TWO;
  wire logic wr_ris = wr_fire && adr == cwg_pkg::ADR_RISE_SRC;
  wire logic wr_fis = wr_fire && adr == cwg_pkg::ADR_FALL_SRC;
  wire logic wr_rsim = wr_fire && adr == cwg_pkg::ADR_RISE_MODE;
  wire logic wr_fsim = wr_fire && adr == cwg_pkg::ADR_FALL_MODE;
  wire logic wr_sdc = wr_fire && adr == cwg_pkg::ADR_SD_CTRL;
  wire logic wr_sds = wr_fire && adr == cwg_pkg::ADR_SD_SRC;
  wire logic wr_alt = wr_fire && adr == cwg_pkg::ADR_ALT_PIN;
  wire logic wr_cnt = wr_fire && cnt_hit;

  // ----------------------------------------------------------
  // Input synchronisers and source routing
  // ----------------------------------------------------------
  wire logic [7:0] ext_in = {fault_input_pin, src_halfbridge_b, src_halfbridge_a,
    src_timer_period_match, src_capture_compare, src_comparator_b, src_comparator_a};
  wire logic fault = alt_q[cwg_pkg::AP_FAULT] ? sync2_q[7] : sync2_q[6]; // RQ1
  wire logic [cwg_pkg::SRC_N-1:0] src7 = {sync2_q[5:3], fault, sync2_q[2:0]};

  // ----------------------------------------------------------
  // Generator clock and control decode
  // ----------------------------------------------------------
  wire logic en = ctl1_q[cwg_pkg::CO_EN];
  wire logic [1:0] clk_src = ctl2_q[cwg_pkg::CT_CLK_LSB +: 2];
  // Fast oscillator shares the system clock here; only the divider slows ticks
  wire logic tick = (clk_src == cwg_pkg::CLK_SRC_DIV) ? (div_q == cwg_pkg::DIV_LAST) : 1'b1;
  wire logic load_done = en & ctl1_q[cwg_pkg::CO_LOAD] & tick;
  wire logic sd_hit = en & |(sds_q[2:0] & {src7[cwg_pkg::RS_CMP_B],
    src7[cwg_pkg::RS_CMP_A], fault});
  wire logic live = (state_q != cwg_pkg::ST_SHUT);
  wire logic run = (state_q == cwg_pkg::ST_RUN);

  cwg_evt_if rise_if ();
  cwg_evt_if fall_if ();
  assign rise_if.src = src7;
  assign rise_if.enable = ris_q[cwg_pkg::SRC_N-1:0]; // RQ17
  assign rise_if.level_mode = rsim_q[cwg_pkg::SRC_N-1:0];
  assign fall_if.src = src7;
  assign fall_if.enable = fis_q[cwg_pkg::SRC_N-1:0];
  assign fall_if.level_mode = fsim_q[cwg_pkg::SRC_N-1:0];

  cwg_event_sel u_rise (.clock(clock), .reset(reset), .port(rise_if.sel));
  cwg_event_sel u_fall (.clock(clock), .reset(reset), .port(fall_if.sel));

  // ----------------------------------------------------------
  // Waveform timing
  // ----------------------------------------------------------
  wire logic rise_ok = live & rise_if.hit & ~rise_pend_q & (rise_blank_q == '0);
  wire logic fall_ok = live & fall_if.hit & ~fall_pend_q & (fall_blank_q == '0);
  wire logic fire_rise = tick & rise_pend_q & (rise_wait_q == '0);
  wire logic fire_fall = tick & fall_pend_q & (fall_wait_q == '0);
  wire logic db_zero = (db_q == '0);
  wire logic p_act = run ? ((wave_q & db_zero) ^ ctl1_q[cwg_pkg::CO_POL_P])
    : sdc_q[cwg_pkg::SD_OVR_P];
  wire logic c_act = run ? ((~wave_q & db_zero) ^ ctl1_q[cwg_pkg::CO_POL_C])
    : sdc_q[cwg_pkg::SD_OVR_C];
  wire logic [7:0] status = {2'b00, c_act, p_act, wave_q, state_q};

  wire logic [7:0] rd_mux =
    (adr == cwg_pkg::ADR_CTRL_ONE) ? ctl1_q :
    (adr == cwg_pkg::ADR_CTRL_TWO) ? ctl2_q :
    (adr == cwg_pkg::ADR_RISE_SRC) ? ris_q :
    (adr == cwg_pkg::ADR_FALL_SRC) ? fis_q :
    (adr == cwg_pkg::ADR_RISE_MODE) ? rsim_q :
    (adr == cwg_pkg::ADR_FALL_MODE) ? fsim_q :
    (adr == cwg_pkg::ADR_SD_CTRL) ? sdc_q :
    (adr == cwg_pkg::ADR_SD_SRC) ? sds_q :
    (adr == cwg_pkg::ADR_ALT_PIN) ? alt_q :
    (adr == cwg_pkg::ADR_STATUS) ? status :
    cnt_hit ? {4'h0, cnt_reg_q[cnt_off[2:0]]} : 8'h00;

  // Shutdown latch: hardware set beats any software clear
  always_comb begin
    sdc_d = wr_sdc ? wdat : sdc_q;
    sdc_d[cwg_pkg::SD_ACTIVE] = sd_hit | (~sdc_d[cwg_pkg::SD_RESTART] // RQ15
      & sdc_d[cwg_pkg::SD_ACTIVE]);
    ctl1_d = wr_ctl1 ? wdat : ctl1_q;
    if (load_done && !wr_ctl1) begin
      ctl1_d[cwg_pkg::CO_LOAD] = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      cwg_pkg::ST_SHUT: if (!sdc_q[cwg_pkg::SD_ACTIVE]) state_d = cwg_pkg::ST_ARM; // RQ16
      cwg_pkg::ST_ARM: begin
        if (sdc_q[cwg_pkg::SD_ACTIVE]) state_d = cwg_pkg::ST_SHUT;
        else if (fire_rise) state_d = cwg_pkg::ST_RUN; // RQ16
      end
      cwg_pkg::ST_RUN: if (sdc_q[cwg_pkg::SD_ACTIVE]) state_d = cwg_pkg::ST_SHUT;
      default: state_d = cwg_pkg::ST_SHUT;
    endcase
    // Sleep is deliberately not a term here: running continues
    if (!en) state_d = cwg_pkg::ST_SHUT; // RQ2
  end

  // ----------------------------------------------------------
  // Bus and configuration registers
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) rdat_q <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctl1_q <= cwg_pkg::REG_RESET;
      ctl2_q <= cwg_pkg::REG_RESET;
      ris_q <= cwg_pkg::REG_RESET;
      fis_q <= cwg_pkg::REG_RESET;
      rsim_q <= cwg_pkg::REG_RESET;
      fsim_q <= cwg_pkg::REG_RESET;
      sdc_q <= cwg_pkg::REG_RESET;
      sds_q <= cwg_pkg::REG_RESET;
      alt_q <= cwg_pkg::REG_RESET;
    end else begin
      ctl1_q <= ctl1_d;
      sdc_q <= sdc_d;
      if (wr_ctl2) ctl2_q <= wdat;
      if (wr_ris) ris_q <= wdat;
      if (wr_fis) fis_q <= wdat;
      if (wr_rsim) rsim_q <= wdat;
      if (wr_fsim) fsim_q <= wdat;
      if (wr_sds) sds_q <= wdat;
      if (wr_alt) alt_q <= wdat;
    end
  end

  // Double-buffered counts: direct while disabled, on load request when enabled
  always_ff @(posedge clock) begin
    for (int i = 0; i < cwg_pkg::CNT_N; i++) begin
      if (reset) begin
        cnt_reg_q[i] <= cwg_pkg::CNT_RESET;
        cnt_buf_q[i] <= cwg_pkg::CNT_RESET;
      end else begin
        if (wr_cnt && cnt_off == 6'(i)) cnt_reg_q[i] <= wdat_cnt;
        if (wr_cnt && cnt_off == 6'(i) && !en) cnt_buf_q[i] <= wdat_cnt; // RQ20
        else if (load_done) cnt_buf_q[i] <= cnt_reg_q[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      div_q <= '0;
    end else begin
      sync1_q <= ext_in;
      sync2_q <= sync1_q;
      div_q <= (div_q == cwg_pkg::DIV_LAST) ? 4'h0 : div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------
  // Waveform engine
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || !live) begin
      state_q <= reset ? cwg_pkg::ST_SHUT : state_d;
      wave_q <= 1'b0;
      rise_pend_q <= 1'b0;
      fall_pend_q <= 1'b0;
      rise_wait_q <= '0;
      fall_wait_q <= '0;
      rise_blank_q <= '0;
      fall_blank_q <= '0;
      db_q <= '0;
    end else begin
      state_q <= state_d;
      // Falling wins a tie so the switch pair never overlaps
      if (fire_fall) wave_q <= 1'b0;
      else if (fire_rise) wave_q <= 1'b1;
      if (rise_ok) rise_pend_q <= 1'b1;
      else if (fire_rise) rise_pend_q <= 1'b0;
      if (fall_ok) fall_pend_q <= 1'b1;
      else if (fire_fall) fall_pend_q <= 1'b0;
      if (rise_ok) rise_wait_q <= cnt_buf_q[cwg_pkg::CI_PHR];
      else if (tick && rise_pend_q && rise_wait_q != '0) rise_wait_q <= rise_wait_q - 4'h1;
      if (fall_ok) fall_wait_q <= cnt_buf_q[cwg_pkg::CI_PHF];
      else if (tick && fall_pend_q && fall_wait_q != '0) fall_wait_q <= fall_wait_q - 4'h1;
      if (fire_rise) fall_blank_q <= cnt_buf_q[cwg_pkg::CI_BKR];
      else if (tick && fall_blank_q != '0) fall_blank_q <= fall_blank_q - 4'h1;
      if (fire_fall) rise_blank_q <= cnt_buf_q[cwg_pkg::CI_BKF];
      else if (tick && rise_blank_q != '0) rise_blank_q <= rise_blank_q - 4'h1;
      if (fire_fall) db_q <= cnt_buf_q[cwg_pkg::CI_DBF];
      else if (fire_rise) db_q <= cnt_buf_q[cwg_pkg::CI_DBR];
      else if (tick && !db_zero) db_q <= db_q - 4'h1;
    end
  end

  // ----------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      prim_q <= 2'b00;
      prim_drv_q <= 2'b00;
      compl_q <= 2'b00;
      compl_drv_q <= 2'b00;
      osc_q <= 1'b0;
    end else begin
      prim_q <= alt_q[cwg_pkg::AP_PRIM] ? {p_act, 1'b0} : {1'b0, p_act}; // RQ1
      compl_q <= alt_q[cwg_pkg::AP_COMPL] ? {c_act, 1'b0} : {1'b0, c_act}; // RQ1
      prim_drv_q <= !(en && ctl1_q[cwg_pkg::CO_OE_P]) ? 2'b00 :
        (alt_q[cwg_pkg::AP_PRIM] ? 2'b10 : 2'b01);
      compl_drv_q <= !(en && ctl1_q[cwg_pkg::CO_OE_C]) ? 2'b00 :
        (alt_q[cwg_pkg::AP_COMPL] ? 2'b10 : 2'b01);
      osc_q <= en && (clk_src == cwg_pkg::CLK_SRC_FAST) && sleep_active; // RQ3
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign primary_output = prim_q;
  assign primary_drive = prim_drv_q;
  assign complementary_output = compl_q;
  assign complementary_drive = compl_drv_q;
  assign fast_osc_keep_on = osc_q;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_prim_route_pin: assert property ( // RQ1
    (primary_drive != 2'b00) |-> primary_drive[1] == $past(alt_q[cwg_pkg::AP_PRIM]))
    else $error("primary output on wrong pin");
  chk_sleep_keeps_run: assert property ( // RQ2
    (run && sleep_active && en && !sdc_q[cwg_pkg::SD_ACTIVE]) |=> run)
    else $error("generator stopped during sleep");
  chk_osc_held_sleep: assert property ( // RQ3
    (en && clk_src == cwg_pkg::CLK_SRC_FAST && sleep_active) |=> fast_osc_keep_on)
    else $error("fast oscillator released while in use");
  chk_restart_clears: assert property ( // RQ15
    (wr_sdc && wdat[cwg_pkg::SD_RESTART] && !sd_hit) |=> !sdc_q[cwg_pkg::SD_ACTIVE])
    else $error("auto-restart left shutdown active");
  chk_arm_waits_rise: assert property ( // RQ16
    (state_q == cwg_pkg::ST_ARM && en && !sdc_q[cwg_pkg::SD_ACTIVE] && !fire_rise)
    |=> state_q == cwg_pkg::ST_ARM)
    else $error("left armed state without rising event");
  chk_run_from_rise: assert property ( // RQ16
    $rose(run) |-> $past(fire_rise) && $past(state_q == cwg_pkg::ST_ARM))
    else $error("run began without rising event");
  chk_direct_load: assert property ( // RQ20
    (wr_cnt && !en && cnt_off == 6'(cwg_pkg::CI_PHR))
    |=> cnt_buf_q[cwg_pkg::CI_PHR] == $past(wdat_cnt))
    else $error("count buffer not loaded while disabled");

  cov_run_reached: cover property (state_q == cwg_pkg::ST_ARM ##1 run);
  cov_shutdown_in_run: cover property (run && sd_hit ##2 state_q == cwg_pkg::ST_SHUT);
  cov_load_transfer: cover property (load_done ##1 !ctl1_q[cwg_pkg::CO_LOAD]);
endmodule

// file: tb/complementary_waveform_setup_bench.sv
// Purpose: Self-checking bench of the waveform generator setup.
// Assumes: Ack in its own time; gates pulled down when released.
// Notes: Bring-up follows the required software order.
`timescale 1ns/1ps
module complementary_waveform_setup_bench;
  logic clock, reset, req, we, sleep, ack, osc_on;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, got;
  logic [6:0] ev;
  logic [1:0] p_out, p_drv, c_out, c_drv, g_p, g_c;
  logic [23:0] rows [4];
  logic [15:0] boot [10];
  int num_errors, n_checks, i;

  cwg_top i_dut (.clock(clock), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .src_comparator_a(ev[0]), .src_comparator_b(ev[1]),
    .src_capture_compare(ev[2]), .src_timer_period_match(ev[3]),
    .src_halfbridge_a(ev[4]), .src_halfbridge_b(ev[5]), .fault_input_pin({1'b0, ev[6]}),
    .sleep_active(sleep), .primary_output(p_out), .primary_drive(p_drv),
    .complementary_output(c_out), .complementary_drive(c_drv), .fast_osc_keep_on(osc_on));
  cwg_switch_model i_sw (.prim_level(p_out), .prim_own(p_drv), .compl_level(c_out),
    .compl_own(c_drv), .gate_prim(g_p), .gate_compl(g_c));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until ack is sampled; one idle cycle follows
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    got = rdat;
    req <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    repeat (3) @(posedge clock);
    ev[k] <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Whole run is far below this span
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sleep = 1'b0;
    ev = 7'h00;
    rows = '{{cwg_pkg::ADR_RISE_SRC, 8'h7f, 8'h7f}, {cwg_pkg::ADR_ALT_PIN, 8'h07, 8'h07},
      {8'h40, 8'ha5, 8'h00}, {cwg_pkg::ADR_STATUS, 8'hff, 8'h01}};
    boot = '{{cwg_pkg::ADR_ALT_PIN, 8'h00}, {cwg_pkg::ADR_CTRL_ONE, 8'h00},
      {cwg_pkg::ADR_SD_SRC, 8'h00}, {cwg_pkg::ADR_SD_CTRL, 8'h09},
      {cwg_pkg::ADR_RISE_SRC, 8'h02}, {cwg_pkg::ADR_FALL_SRC, 8'h00},
      {cwg_pkg::ADR_RISE_MODE, 8'h00}, {cwg_pkg::ADR_FALL_MODE, 8'h00},
      {cwg_pkg::ADR_CTRL_TWO, 8'h01}, {cwg_pkg::ADR_CTRL_ONE, 8'h18}};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, cwg_pkg::ADR_RISE_SRC, 8'h00);
    chk(got, 32'h0);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      bus(1'b0, rows[i][23:16], 8'h00);
      chk(got, {24'h0, rows[i][7:0]});
    end
    for (i = 0; i < 10; i++) bus(1'b1, boot[i][15:8], boot[i][7:0]);
    // Count i into slot i: rising phase delay becomes 4 ticks
    for (i = 0; i < 6; i++) bus(1'b1, 8'(8'h24 + 4 * i), 8'(i));
    chk(32'({p_drv, c_drv}), 32'h0);
    bus(1'b1, cwg_pkg::ADR_CTRL_ONE, 8'h19);
    sleep <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(osc_on), 32'h1);
    chk(32'({g_p[0], g_c[0]}), 32'h1);
    bus(1'b1, cwg_pkg::ADR_SD_CTRL, 8'h08);
    pulse(0);
    repeat (12) @(posedge clock);
    chk(32'(g_p[0]), 32'h0);
    pulse(6);
    repeat (12) @(posedge clock);
    chk(32'(g_p[0]), 32'h0);
    pulse(1);
    i = 0;
    while (g_p[0] !== 1'b1 && i < 30) begin
      @(posedge clock);
      i++;
    end
    chk(32'({g_p[0], g_c[0]}), 32'h2);
    // Three cycles of pipeline plus four phase ticks loaded while disabled
    chk(32'(i), 32'h7);
    bus(1'b0, cwg_pkg::ADR_STATUS, 8'h00);
    chk(32'(got[2:0]), 32'h4);
    sleep <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(osc_on), 32'h0);
    bus(1'b1, cwg_pkg::ADR_ALT_PIN, 8'h03);
    repeat (4) @(posedge clock);
    chk(32'({p_drv, c_drv}), 32'ha);
    bus(1'b1, cwg_pkg::ADR_SD_CTRL, 8'h09);
    bus(1'b1, cwg_pkg::ADR_SD_CTRL, 8'h0b);
    repeat (3) @(posedge clock);
    bus(1'b0, cwg_pkg::ADR_SD_CTRL, 8'h00);
    chk(got, 32'h0a);
    // Reset while armed must drop every pin and the shutdown control register
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    chk(32'({p_out, p_drv, c_out, c_drv, osc_on}), 32'h0);
    bus(1'b0, cwg_pkg::ADR_SD_CTRL, 8'h00);
    chk(got, 32'h0);
    close_out();
  end
endmodule

// file: tb/cwg_switch_model.sv
// Purpose: Gate drivers of the external power switches.
// Assumes: Each gate line has a pull-down resistor.
// Notes: A released pin reads low, never its last value.
`timescale 1ns/1ps
module cwg_switch_model (
  input wire logic [1:0] prim_level,
  input wire logic [1:0] prim_own,
  input wire logic [1:0] compl_level,
  input wire logic [1:0] compl_own,
  output logic [1:0] gate_prim,
  output logic [1:0] gate_compl
);
  // Pull-down wins once the generator lets go of a pin
  // Pins are taken as digital only; an analog pin would read nothing here
  assign gate_prim = prim_level & prim_own;
  assign gate_compl = compl_level & compl_own;
endmodule
